// ==== hw/aas_pkg.sv ====
package aas_pkg;
	// Register byte offsets on the AHB-Lite slave.
	localparam logic [7:0] AAS_OFF_CTRL = 8'h00;
	localparam logic [7:0] AAS_OFF_REF = 8'h04;
	localparam logic [7:0] AAS_OFF_INPUT = 8'h08;
	localparam logic [7:0] AAS_OFF_AVG = 8'h0C;
	localparam logic [7:0] AAS_OFF_SEQMASK = 8'h10;
	localparam logic [7:0] AAS_OFF_TRIG = 8'h14;
	localparam logic [7:0] AAS_OFF_SEQSTAT = 8'h18;
	localparam logic [7:0] AAS_OFF_RESULT = 8'h1C;
	localparam logic [7:0] AAS_OFF_FLAGS = 8'h20;
	localparam logic [7:0] AAS_OFF_MASK = 8'h24;
	// Control register fields.
	localparam int AAS_CTRL_EN_BIT = 0;
	localparam int AAS_CTRL_FREE_BIT = 1;
	localparam int AAS_CTRL_DIFF_BIT = 2;
	localparam int AAS_CTRL_DIV_LSB = 8;
	// Input selection fields.
	localparam int AAS_POS_LSB = 0;
	localparam int AAS_NEG_LSB = 8;
	// Averaging fields.
	localparam int AAS_CNT_LSB = 0;
	localparam int AAS_ADJ_LSB = 4;
	// Status and flag fields.
	localparam int AAS_SEQ_RUN_BIT = 31;
	localparam int AAS_FLAG_RDY_BIT = 0;
	localparam int AAS_FLAG_OVR_BIT = 1;
	localparam int AAS_TRIG_START_BIT = 0;
	// Reset values.
	localparam logic [1:0] AAS_REF_INTERNAL = 2'h0;
	localparam logic [2:0] AAS_DIV_RESET = 3'h0;
	// Accumulation limits.
	localparam logic [3:0] AAS_CNT_MAX = 4'hA;
	localparam logic [3:0] AAS_CNT_AUTO_FROM = 4'h4;
	localparam int AAS_ACC_W = 22;
	localparam int AAS_SAMPLE_W = 12;
	localparam int AAS_RES_W = 16;
	localparam int AAS_INPUTS = 32;
	// Prescaler counter width; divide-by-two is setting zero.
	localparam int AAS_DIV_W = 8;
	localparam logic [7:0] AAS_DIV_BASE = 8'h02;
endpackage

// ==== hw/aas_tick_if.sv ====
`timescale 1ns/1ps
interface aas_tick_if;
	logic run;
	logic [2:0] div_sel;
	logic tick;
	modport core (output run, output div_sel, input tick);
	modport presc (input run, input div_sel, output tick);
endinterface // aas_tick_if

// ==== hw/aas_prescaler.sv ====
`timescale 1ns/1ps
module aas_prescaler
	import aas_pkg::*;
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Rate link to the sequencer.
	aas_tick_if.presc tk
);
	logic [AAS_DIV_W-1:0] cnt;
	logic [AAS_DIV_W-1:0] next_cnt;
	logic [AAS_DIV_W-1:0] limit;
	logic tick;
	logic next_tick;

	// Division is two shifted left by the setting, so it never goes below two.
	always_comb begin
		limit = AAS_DIV_W'((AAS_DIV_BASE << tk.div_sel) - 8'h01);
		next_cnt = cnt;
		next_tick = 1'b0;
		if (!tk.run) begin
			next_cnt = '0;
		end else if (cnt >= limit) begin
			next_cnt = '0;
			next_tick = 1'b1;
		end else begin
			next_cnt = cnt + 8'h01;
		end
	end

	// Registered so the tick is a clean one-cycle enable.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= '0;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end

	assign tk.tick = tick;
endmodule // aas_prescaler

// ==== hw/aas_top.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Conversions run on prescaled kernel clock enable.
// - Prescaler divides by two at least.
// - Reference select resets to internal reference.
// - Count codes 6..A accumulate 64..1024 samples.
// - Automatic shifts 1..6 give 16-bit results.
// - Total shift is automatic plus adjustable.
// - One start converts every masked input.
// - Masked inputs visited in ascending order.
// - Negative input fixed for whole sequence.
// - Running bit set at start of a masked sequence, cleared at end.
// - Status holds index just converted.
// - Each conversion writes result, sets ready.
// - Next masked input starts without trigger.
// - Empty mask converts selected positive input.
// - Unread result overwritten with multi-channel sets overrun.
// - Free-running restarts after each sequence ends.
module aas_top
	import aas_pkg::*;
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Analog front end.
	output logic conv_req,
	output logic [4:0] pos_input,
	output logic [4:0] neg_input,
	output logic diff_mode,
	output logic [1:0] reference_sel,
	input wire logic sample_done,
	input wire logic [11:0] sample_data,
	// Interrupt.
	output logic irq
);
	typedef enum logic [2:0] {AAS_IDLE, AAS_REQ, AAS_HI, AAS_LO, AAS_FIN} aas_state_e;

	aas_tick_if tk ();

	// Lowest set mask bit at or above a starting index; top bit flags a find.
	function automatic logic [5:0] aas_find(input logic [31:0] m,
		input logic [5:0] lo);
		logic [5:0] r;
		r = '0;
		for (int i = AAS_INPUTS - 1; i >= 0; i--) begin
			if (m[i] && (6'(i) >= lo)) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction

	// Bus address phase capture.
	logic wr_pend, next_wr_pend;
	logic [7:0] wr_addr, next_wr_addr;
	logic [31:0] next_hrdata;
	logic addr_ok;
	logic rd_result;
	logic wr_now;
	// Software configuration.
	logic enable, free_run, next_enable, next_free_run, next_diff;
	logic [2:0] div_sel, next_div_sel;
	logic [1:0] next_ref;
	logic [4:0] pos_sel, neg_sel, next_pos_sel, next_neg_sel;
	logic [3:0] count_sel, next_count_sel;
	logic [2:0] adjust_shift, next_adjust_shift;
	logic [31:0] sequence_input_mask, next_seq_mask_reg;
	logic [1:0] int_mask, next_int_mask;
	logic sw_start;
	// Conversion engine.
	aas_state_e state, next_state;
	logic [10:0] cnt, next_cnt, total;
	logic [AAS_ACC_W-1:0] acc, next_acc;
	logic [AAS_RES_W-1:0] result, next_result;
	logic [4:0] cur, next_cur, seq_cur, next_seq_cur;
	logic [4:0] next_neg_input;
	logic [31:0] run_mask, next_run_mask;
	logic running, next_running, free_pend, next_free_pend;
	logic flag_rdy, flag_ovr, next_flag_rdy, next_flag_ovr;
	logic unread, next_unread, next_req;
	logic [3:0] auto_shift, total_shift;
	logic [5:0] first, nxt;
	logic multi;
	// Synchroniser for the front-end completion level.
	logic done_m, done_s;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq = |({flag_ovr, flag_rdy} & int_mask);
	assign tk.run = enable;
	assign tk.div_sel = div_sel;
	assign wr_now = wr_pend;
	assign sw_start = wr_now && (wr_addr == AAS_OFF_TRIG) &&
		hwdata[AAS_TRIG_START_BIT];

	// Read data is latched in the address phase, so no wait states.
	always_comb begin
		addr_ok = hsel && htrans[1] && hready;
		next_wr_pend = addr_ok && hwrite;
		next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
		rd_result = addr_ok && !hwrite && (haddr[7:0] == AAS_OFF_RESULT);
		next_hrdata = hrdata;
		if (addr_ok && !hwrite) begin
			case (haddr[7:0])
				AAS_OFF_CTRL: next_hrdata = {21'h0, div_sel, 5'h0, diff_mode,
					free_run, enable};
				AAS_OFF_REF: next_hrdata = {30'h0, reference_sel};
				AAS_OFF_INPUT: next_hrdata = {19'h0, neg_sel, 3'h0, pos_sel};
				AAS_OFF_AVG: next_hrdata = {25'h0, adjust_shift, count_sel};
				AAS_OFF_SEQMASK: next_hrdata = sequence_input_mask;
				AAS_OFF_SEQSTAT: next_hrdata = {running, 26'h0, seq_cur};
				AAS_OFF_RESULT: next_hrdata = {16'h0, result};
				AAS_OFF_FLAGS: next_hrdata = {30'h0, flag_ovr, flag_rdy};
				AAS_OFF_MASK: next_hrdata = {30'h0, int_mask};
				default: next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	// Configuration writes; only whole-word stores are expected.
	always_comb begin
		next_enable = enable;
		next_free_run = free_run;
		next_diff = diff_mode;
		next_div_sel = div_sel;
		next_ref = reference_sel;
		next_pos_sel = pos_sel;
		next_neg_sel = neg_sel;
		next_count_sel = count_sel;
		next_adjust_shift = adjust_shift;
		next_seq_mask_reg = sequence_input_mask;
		next_int_mask = int_mask;
		if (wr_now) begin
			case (wr_addr)
				AAS_OFF_CTRL: begin
					next_enable = hwdata[AAS_CTRL_EN_BIT];
					next_free_run = hwdata[AAS_CTRL_FREE_BIT];
					next_diff = hwdata[AAS_CTRL_DIFF_BIT];
					next_div_sel = hwdata[AAS_CTRL_DIV_LSB +: 3];
				end
				AAS_OFF_REF: next_ref = hwdata[1:0];
				AAS_OFF_INPUT: begin
					next_pos_sel = hwdata[AAS_POS_LSB +: 5];
					next_neg_sel = hwdata[AAS_NEG_LSB +: 5];
				end
				AAS_OFF_AVG: begin
					next_count_sel = hwdata[AAS_CNT_LSB +: 4];
					next_adjust_shift = hwdata[AAS_ADJ_LSB +: 3];
				end
				AAS_OFF_SEQMASK: next_seq_mask_reg = hwdata;
				AAS_OFF_MASK: next_int_mask = hwdata[1:0];
				default: next_enable = enable;
			endcase
		end
	end

	// Bus and configuration registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
			enable <= 1'b0;
			free_run <= 1'b0;
			diff_mode <= 1'b0;
			div_sel <= AAS_DIV_RESET;
			reference_sel <= AAS_REF_INTERNAL;
			pos_sel <= 5'h00;
			neg_sel <= 5'h00;
			count_sel <= 4'h0;
			adjust_shift <= 3'h0;
			sequence_input_mask <= 32'h0000_0000;
			int_mask <= 2'h0;
		end else begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			enable <= next_enable;
			free_run <= next_free_run;
			diff_mode <= next_diff;
			div_sel <= next_div_sel;
			reference_sel <= next_ref;
			pos_sel <= next_pos_sel;
			neg_sel <= next_neg_sel;
			count_sel <= next_count_sel;
			adjust_shift <= next_adjust_shift;
			sequence_input_mask <= next_seq_mask_reg;
			int_mask <= next_int_mask;
		end
	end

	// Sample count and shifts; reserved count codes act as one sample.
	always_comb begin
		total = (count_sel <= AAS_CNT_MAX) ? (11'h001 << count_sel) : 11'h001;
		auto_shift = (count_sel > AAS_CNT_AUTO_FROM && count_sel <= AAS_CNT_MAX) ?
			4'(count_sel - AAS_CNT_AUTO_FROM) : 4'h0;
		total_shift = auto_shift + {1'b0, adjust_shift};
		first = (sequence_input_mask == '0) ? {1'b1, pos_sel} :
			aas_find(sequence_input_mask, 6'h00);
		nxt = aas_find(run_mask, {1'b0, cur} + 6'h01);
		multi = (run_mask & (run_mask - 32'h1)) != '0;
	end

	// Conversion engine: sample handshake, accumulate, then sequence step.
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_acc = acc;
		next_result = result;
		next_cur = cur;
		next_seq_cur = seq_cur;
		next_neg_input = neg_input;
		next_run_mask = run_mask;
		next_running = running;
		next_free_pend = free_pend;
		next_req = conv_req;
		next_unread = unread && !rd_result;
		// Software clears by writing one; a same-cycle set still wins.
		next_flag_rdy = flag_rdy && !(wr_now && wr_addr == AAS_OFF_FLAGS &&
			hwdata[AAS_FLAG_RDY_BIT]);
		next_flag_ovr = flag_ovr && !(wr_now && wr_addr == AAS_OFF_FLAGS &&
			hwdata[AAS_FLAG_OVR_BIT]);
		case (state)
			AAS_IDLE: begin
				if (enable && (sw_start || free_pend)) begin
					next_free_pend = 1'b0;
					next_run_mask = sequence_input_mask;
					next_neg_input = neg_sel;
					next_cur = first[4:0];
					next_running = sequence_input_mask != '0;
					next_cnt = '0;
					next_acc = '0;
					next_state = AAS_REQ;
				end
			end
			AAS_REQ: begin
				if (tk.tick) begin
					next_req = 1'b1;
					next_state = AAS_HI;
				end
			end
			AAS_HI: begin
				if (done_s) begin
					next_acc = acc + AAS_ACC_W'(sample_data);
					next_req = 1'b0;
					next_state = AAS_LO;
				end
			end
			AAS_LO: begin
				if (!done_s && tk.tick) begin
					next_cnt = cnt + 11'h001;
					next_state = (cnt + 11'h001 == total) ? AAS_FIN : AAS_REQ;
				end
			end
			AAS_FIN: begin
				next_result = AAS_RES_W'(acc >> total_shift);
				next_flag_rdy = 1'b1;
				next_unread = 1'b1;
				if (unread && !rd_result && multi) begin
					next_flag_ovr = 1'b1;
				end
				next_seq_cur = cur;
				next_cnt = '0;
				next_acc = '0;
				if (run_mask != '0 && nxt[5]) begin
					next_cur = nxt[4:0];
					next_state = AAS_REQ;
				end else begin
					next_running = 1'b0;
					next_free_pend = free_run;
					next_state = AAS_IDLE;
				end
			end
			default: next_state = AAS_IDLE;
		endcase
		// Disabling abandons the conversion and drops the request.
		if (!enable && state != AAS_IDLE) begin
			next_state = AAS_IDLE;
			next_req = 1'b0;
			next_running = 1'b0;
			next_free_pend = 1'b0;
		end
	end

	// Engine registers; the done level is synchronised before use.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= AAS_IDLE;
			cnt <= '0;
			acc <= '0;
			result <= '0;
			cur <= 5'h00;
			seq_cur <= 5'h00;
			pos_input <= 5'h00;
			neg_input <= 5'h00;
			run_mask <= 32'h0000_0000;
			running <= 1'b0;
			free_pend <= 1'b0;
			flag_rdy <= 1'b0;
			flag_ovr <= 1'b0;
			unread <= 1'b0;
			conv_req <= 1'b0;
			done_m <= 1'b0;
			done_s <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			acc <= next_acc;
			result <= next_result;
			cur <= next_cur;
			seq_cur <= next_seq_cur;
			pos_input <= next_cur;
			neg_input <= next_neg_input;
			run_mask <= next_run_mask;
			running <= next_running;
			free_pend <= next_free_pend;
			flag_rdy <= next_flag_rdy;
			flag_ovr <= next_flag_ovr;
			unread <= next_unread;
			conv_req <= next_req;
			done_m <= sample_done;
			done_s <= done_m;
		end
	end

	aas_prescaler u_presc (
		.hclk(hclk),
		.hresetn(hresetn),
		.tk(tk.presc)
	);
endmodule // aas_top

// ==== dv/aas_asserts.sv ====
`timescale 1ns/1ps
module aas_asserts
	import aas_pkg::*;
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Bus side.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Front end side.
	input wire logic conv_req,
	input wire logic [4:0] pos_input,
	input wire logic [4:0] neg_input,
	input wire logic [1:0] reference_sel,
	input wire logic sample_done,
	input wire logic irq
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// The slave never stalls and never errors.
	okay_resp_a: assert property (hreadyout && !hresp)
		else $error("bus response not ready and okay");
	// Outputs come out of reset idle, on the internal reference.
	reset_out_a: assert property ($rose(hresetn) |->
		reference_sel == AAS_REF_INTERNAL && !irq && !conv_req)
		else $error("outputs wrong after reset");
	// A request stands until the front end answers.
	req_hold_a: assert property (conv_req && !sample_done |=> conv_req)
		else $error("request dropped before answer");
	// An answer ends the request within the synchroniser delay.
	req_drop_a: assert property ($rose(sample_done) |-> ##[1:4] !conv_req)
		else $error("request not dropped after answer");
	// The input must not change under a standing request.
	pos_stable_a: assert property (conv_req && $past(conv_req) |->
		$stable(pos_input))
		else $error("positive input moved during request");
	// The negative input holds over the cycle after a request rises.
	neg_stable_a: assert property ($rose(conv_req) ##1 conv_req |->
		neg_input == $past(neg_input))
		else $error("negative input moved during request");
	// Requests are spaced by the divided tick and handshake.
	req_gap_a: assert property ($fell(conv_req) |-> !conv_req [*3])
		else $error("requests too close together");
	// Reads of unmapped places return zero.
	unmapped_rd_a: assert property (hsel && hready && htrans[1] && !hwrite
		&& haddr[31:8] == 24'h00_0000 && haddr[7:0] > AAS_OFF_MASK
		|=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	// Main scenarios reached.
	cover property ($rose(conv_req));
	cover property ($rose(irq));
	cover property ($fell(conv_req) && pos_input == 5'h1F);
endmodule // aas_asserts

bind aas_top aas_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hreadyout, .hresp, .hrdata, .conv_req, .pos_input,
	.neg_input, .reference_sel, .sample_done, .irq);

// ==== dv/aas_front_model.sv ====
`timescale 1ns/1ps
module aas_front_model (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Request from the converter.
	input wire logic conv_req,
	input wire logic [4:0] pos_input,
	input wire logic slow,
	// Sample back.
	output logic sample_done,
	output logic [11:0] sample_data
);
	logic [2:0] wait_cnt;

	// Each input gives its own value so the scan order shows in results.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sample_done <= 1'b0;
			sample_data <= 12'h000;
			wait_cnt <= 3'h0;
		end else if (conv_req && !sample_done) begin
			wait_cnt <= wait_cnt + 3'h1;
			if (wait_cnt >= {slow, 2'h0}) begin
				sample_done <= 1'b1;
				sample_data <= {pos_input, 7'h7F};
				wait_cnt <= 3'h0;
			end
		end else if (!conv_req && sample_done) begin
			// Released data is inverted so stale values never match.
			sample_done <= 1'b0;
			sample_data <= ~sample_data;
		end
	end
endmodule // aas_front_model

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	import aas_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hready, hreadyout, hresp, conv_req, diff_mode, sample_done, irq;
	logic [31:0] hrdata, q;
	logic [4:0] pos_input, neg_input;
	logic [1:0] reference_sel;
	logic [11:0] sample_data;
	logic slow = 1'b0;
	logic prev_req = 1'b0;
	logic [9:0] seen [$];
	logic [4:0] exp_seq [3] = '{5'h02, 5'h05, 5'h1F};
	// Rows: positive input, count code, adjust shift, expected result.
	logic [27:0] rows [7] = '{{5'h03, 4'h0, 3'h0, 16'h01FF},
		{5'h03, 4'h2, 3'h1, 16'h03FE}, {5'h03, 4'h4, 3'h2, 16'h07FC},
		{5'h03, 4'h6, 3'h1, 16'h0FF8}, {5'h09, 4'h8, 3'h0, 16'h4FF0},
		{5'h03, 4'h7, 3'h4, 16'h01FF}, {5'h1F, 4'hA, 3'h0, 16'hFFF0}};
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int rises = 0;
	int rises_at = 0;

	assign hready = hreadyout;
	always #10 hclk = ~hclk;

	aas_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hreadyout, .hresp, .hrdata, .conv_req,
		.pos_input, .neg_input, .diff_mode, .reference_sel, .sample_done,
		.sample_data, .irq);
	aas_front_model fe (.hclk, .hresetn, .conv_req, .pos_input, .slow,
		.sample_done, .sample_data);

	task automatic final_report();
		if (fail_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask

	// One single word transfer; waits on hready in both phases.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
		do bus(1'b0, a, 32'h0000_0000, q); while (q[b] !== v);
	endtask

	// Log each new request; the timeout also lives here.
	always @(posedge hclk) begin
		prev_req <= conv_req;
		cyc <= cyc + 1;
		if (conv_req && !prev_req) begin
			seen.push_back({neg_input, pos_input});
			rises <= rises + 1;
		end
		if (cyc == 60000) begin
			fail_count++;
			final_report();
		end
	end

	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, AAS_OFF_REF, 32'h0000_0000, q);
		chk("ref", q, 32'h0000_0000);
		chk("ref_pin", {30'h0, reference_sel}, 32'h0000_0000);
		bus(1'b0, AAS_OFF_CTRL, 32'h0000_0000, q);
		chk("ctrl", q, 32'h0000_0000);
		bus(1'b0, 8'h3C, 32'h0000_0000, q);
		chk("unmapped", q, 32'h0000_0000);
		bus(1'b1, AAS_OFF_MASK, 32'h0000_0001, q);
		bus(1'b1, AAS_OFF_CTRL, 32'h0000_0001, q);
		foreach (rows[i]) begin
			bus(1'b1, AAS_OFF_AVG,
				{25'h0, rows[i][18:16], rows[i][22:19]}, q);
			bus(1'b1, AAS_OFF_INPUT, {27'h0, rows[i][27:23]}, q);
			bus(1'b1, AAS_OFF_TRIG, 32'h0000_0001, q);
			wait_bit(AAS_OFF_FLAGS, 0, 1'b1);
			chk("irq", irq, 32'h1);
			bus(1'b0, AAS_OFF_RESULT, 32'h0000_0000, q);
			chk("result", q, {16'h0, rows[i][15:0]});
			bus(1'b1, AAS_OFF_MASK, 32'h0000_0000, q);
			@(posedge hclk);
			chk("masked", irq, 32'h0);
			bus(1'b1, AAS_OFF_MASK, 32'h0000_0001, q);
			bus(1'b1, AAS_OFF_FLAGS, 32'h0000_0003, q);
			@(posedge hclk);
			chk("cleared", irq, 32'h0);
			chk("pos", seen[$], {5'h00, rows[i][27:23]});
		end
		// Three-input scan in differential mode, results left unread.
		bus(1'b1, AAS_OFF_CTRL, 32'h0000_0105, q);
		bus(1'b1, AAS_OFF_INPUT, 32'h0000_0700, q);
		bus(1'b1, AAS_OFF_AVG, 32'h0000_0000, q);
		bus(1'b1, AAS_OFF_SEQMASK, 32'h8000_0024, q);
		seen.delete();
		bus(1'b1, AAS_OFF_TRIG, 32'h0000_0001, q);
		bus(1'b0, AAS_OFF_SEQSTAT, 32'h0000_0000, q);
		chk("busy", q[31], 32'h1);
		wait_bit(AAS_OFF_SEQSTAT, 31, 1'b0);
		chk("state", q, 32'h0000_001F);
		chk("diff", diff_mode, 32'h1);
		bus(1'b0, AAS_OFF_FLAGS, 32'h0000_0000, q);
		chk("overrun", q, 32'h0000_0003);
		bus(1'b0, AAS_OFF_RESULT, 32'h0000_0000, q);
		chk("last", q, 32'h0000_0FFF);
		chk("count", seen.size(), 32'h3);
		foreach (exp_seq[i]) chk("order", seen[i], {5'h07, exp_seq[i]});
		// Free running with a slow front end, one start only.
		bus(1'b1, AAS_OFF_SEQMASK, 32'h0000_0000, q);
		bus(1'b1, AAS_OFF_CTRL, 32'h0000_0003, q);
		slow <= 1'b1;
		bus(1'b1, AAS_OFF_TRIG, 32'h0000_0001, q);
		rises_at = rises;
		repeat (300) @(posedge hclk);
		chk("free", rises > rises_at + 2, 32'h1);
		@(posedge sample_done);
		bus(1'b1, AAS_OFF_CTRL, 32'h0000_0000, q);
		// Reset after disabling must bring the reference and flags back.
		bus(1'b1, AAS_OFF_REF, 32'h0000_0003, q);
		bus(1'b0, AAS_OFF_REF, 32'h0000_0000, q);
		chk("ref_set", q, 32'h0000_0003);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, AAS_OFF_REF, 32'h0000_0000, q);
		chk("ref_rst", q, 32'h0000_0000);
		bus(1'b0, AAS_OFF_FLAGS, 32'h0000_0000, q);
		chk("flags_rst", q, 32'h0000_0000);
		final_report();
	end
endmodule // testbench
